// ---- verilog/pcc_frame_config.sv ----
// Purpose: configuration register, status flags and transmit detection delay line
// Assumes: register port is the internal side of the serial management block
// Notes:   frame parsing beyond the destination address is done outside
`timescale 1ns/1ps
module pcc_frame_config #(
  parameter int          BUF_UNIT  = 4,
  parameter int          MEM_AW    = 6,
  parameter logic [47:0] DA_FIRST  = 48'h0000_0000_0002,
  parameter logic [47:0] DA_SECOND = 48'h0000_0000_0004
) (
  input  wire logic                    CORE_CLK_I,
  input  wire logic                    RST_N_I,
  input  wire logic                    STRAP_EN_I,
  input  wire logic [4:0]              PHY_ADDR_I,
  input  wire pcc_pkg::pcc_regbus_type REG_I,
  output      logic [15:0]             REG_RDATA_O,
  input  wire pcc_pkg::pcc_tx_type     TX_I,
  output      pcc_pkg::pcc_tx_type     TX_O,
  input  wire logic                    FRAME_PHYAD_VALID_I,
  input  wire logic [4:0]              FRAME_PHYAD_I,
  input  wire logic                    FRAME_DONE_I,
  input  wire logic                    FRAME_ERR_I,
  output      logic                    CTRL_FRAME_O,
  output      logic                    ADDR_ACCEPT_O,
  output      logic                    FRAME_WR_EN_O,
  output      logic                    IRQ_SLOT_SEL_O,
  output      logic                    IRQ_EVENT_O
);
  import pcc_pkg::*;

  localparam int MEM_SIZE = 1 << MEM_AW;

  // ==========================================================
  // state
  typedef struct packed {
    logic                strap_done;
    logic                err_flag;
    logic                ok_flag;
    logic                da_sel;
    logic [1:0]          irq_ctl;
    logic                bc_reject;
    logic [3:0]          buf_size;
    logic                wr_en;
    logic [15:0]         rdata;
    pcc_state_type       st;
    logic [3:0]          nib;
    logic [47:0]         da;
    logic                ctrl;
    logic                accept;
    logic                trunc;
    logic [MEM_AW-1:0]   wp;
    pcc_tx_type          tx;
    logic                irq;
    logic                slot;
  } pcc_core_type;

  pcc_core_type r;
  pcc_core_type next_r;

  pcc_tx_type   mem [MEM_SIZE];
  pcc_tx_type   delayed;
  logic [MEM_AW-1:0] depth;
  logic [15:0]  cfg_word;
  logic [47:0]  sel_addr;
  logic [47:0]  cand;
  logic         set_err;
  logic         set_ok;
  logic         cfg_rd;
  logic         cfg_wr;

  // ==========================================================
  // delay line
  always_comb
  begin
    depth   = MEM_AW'(32'(r.buf_size) * BUF_UNIT);
    delayed = mem[r.wp - depth];
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    mem[r.wp] <= TX_I;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_r   = r;
    cfg_rd   = REG_I.rd && (REG_I.addr == CFG_ADDR);
    cfg_wr   = REG_I.wr && (REG_I.addr == CFG_ADDR);
    set_err  = FRAME_DONE_I && FRAME_ERR_I;
    set_ok   = FRAME_DONE_I && !FRAME_ERR_I;
    cfg_word = {r.err_flag, r.ok_flag, 5'h00, r.da_sel, r.irq_ctl,
                r.bc_reject, r.buf_size, r.wr_en};
    sel_addr = r.da_sel ? DA_SECOND : DA_FIRST;
    cand     = {TX_I.d, r.da[47:4]};

    // strap is caught on the first clock after reset release
    if (!r.strap_done)
    begin
      next_r.strap_done = 1'b1;
      next_r.wr_en      = STRAP_EN_I;
    end

    if (cfg_wr)
    begin
      next_r.da_sel    = REG_I.wdata[DA_SEL_BIT];
      next_r.irq_ctl   = REG_I.wdata[IRQ_CTL_HI:IRQ_CTL_LO];
      next_r.bc_reject = REG_I.wdata[BC_REJECT_BIT];
      next_r.buf_size  = REG_I.wdata[BUF_HI:BUF_LO];
      next_r.wr_en     = REG_I.wdata[WR_EN_BIT];
    end

    // kept as its own flop so the slot select leaves straight from a register
    next_r.slot = |next_r.irq_ctl;

    if (cfg_rd)
    begin
      next_r.rdata    = cfg_word;
      next_r.err_flag = 1'b0;
      next_r.ok_flag  = 1'b0;
    end
    // an event in the read cycle survives the clear
    if (set_err)
      next_r.err_flag = 1'b1;
    if (set_ok)
      next_r.ok_flag = 1'b1;

    next_r.irq = (set_ok && r.irq_ctl[0]) || (set_err && r.irq_ctl[1]);

    if (FRAME_PHYAD_VALID_I)
    begin
      if (r.bc_reject)
        next_r.accept = (FRAME_PHYAD_I == PHY_ADDR_I);
      else
        next_r.accept = (FRAME_PHYAD_I == PHY_ADDR_I) ||
                        (FRAME_PHYAD_I == BCAST_PHYAD);
    end

    // destination address collection, first nibble lands in the low bits
    case (r.st)
      ST_IDLE:
      begin
        next_r.ctrl  = 1'b0;
        next_r.trunc = 1'b0;
        if (TX_I.en && (TX_I.d == SFD_NIBBLE))
        begin
          next_r.st  = ST_DA;
          next_r.nib = 4'h0;
        end
      end
      ST_DA:
      begin
        next_r.da  = cand;
        next_r.nib = r.nib + 4'h1;
        if (!TX_I.en)
          next_r.st = ST_IDLE;
        else if (r.nib == DA_LAST_NIB)
        begin
          next_r.st   = ST_BODY;
          next_r.ctrl = (cand == sel_addr) ||
                        (cand == (sel_addr | 48'h0000_0000_0001));
          // without buffering the match is only known once the address is gone
          next_r.trunc = (r.buf_size == BUF_RESET) && next_r.ctrl;
        end
      end
      ST_BODY:
      begin
        if (!TX_I.en)
        begin
          next_r.st    = ST_IDLE;
          next_r.trunc = 1'b0;
        end
      end
      default:
        next_r.st = ST_IDLE;
    endcase

    next_r.wp = r.wp + 1'b1;
    if (r.buf_size == BUF_RESET)
    begin
      next_r.tx    = TX_I;
      // the last address nibble still leaves; only what follows it is cut
      next_r.tx.en = TX_I.en && !r.trunc;
    end
    else
      next_r.tx = delayed;
  end

  // ==========================================================
  // registers
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      r            <= '0;
      r.st         <= ST_IDLE;
      r.irq_ctl    <= IRQ_CTL_RESET;
      r.buf_size   <= BUF_RESET;
    end
    else
      r <= next_r;
  end

  always_comb
  begin
    REG_RDATA_O    = r.rdata;
    TX_O           = r.tx;
    CTRL_FRAME_O   = r.ctrl;
    ADDR_ACCEPT_O  = r.accept;
    FRAME_WR_EN_O  = r.wr_en;
    IRQ_SLOT_SEL_O = r.slot;
    IRQ_EVENT_O    = r.irq;
  end

endmodule : pcc_frame_config

// ---- verilog/pcc_pkg.sv ----
// Purpose: constants and carrier types for the control-frame configuration block
// Assumes: 16-bit management registers, 5-bit register address, MII nibble transmit path
// Notes:   field positions and the irq control and buffer size reset values of the configuration register live here
package pcc_pkg;

  localparam logic [4:0] CFG_ADDR       = 5'h1F;
  localparam int         ERR_BIT        = 15;
  localparam int         OK_BIT         = 14;
  localparam int         DA_SEL_BIT     = 8;
  localparam int         IRQ_CTL_HI     = 7;
  localparam int         IRQ_CTL_LO     = 6;
  localparam int         BC_REJECT_BIT  = 5;
  localparam int         BUF_HI         = 4;
  localparam int         BUF_LO         = 1;
  localparam int         WR_EN_BIT      = 0;
  localparam logic [4:0] BCAST_PHYAD    = 5'h1F;
  localparam logic [3:0] SFD_NIBBLE     = 4'hD;
  localparam logic [3:0] DA_LAST_NIB    = 4'hB;
  localparam logic [1:0] IRQ_CTL_RESET  = 2'h0;
  localparam logic [3:0] BUF_RESET      = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DA   = 3'b010,
    ST_BODY = 3'b100
  } pcc_state_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } pcc_regbus_type;

  typedef struct packed {
    logic       en;
    logic [3:0] d;
  } pcc_tx_type;

endpackage : pcc_pkg

// ---- test/pcc_mac_model.sv ----
// Purpose: MAC transmit source
// Assumes: drives at the falling edge
// Notes:   idle data is the inverse of the last nibble
`timescale 1ns/1ps
module pcc_mac_model (
  input  wire logic                clk_i,
  output      pcc_pkg::pcc_tx_type tx_o
);
  import pcc_pkg::*;
  initial tx_o = '0;
  // sfd, address low nibble first, two body nibbles
  task automatic head(input logic [47:0] da);
    for (int i = -1; i < 14; i++)
    begin
      @(negedge clk_i);
      tx_o = '{1'b1, i < 0 ? SFD_NIBBLE : i < 12 ? da[4*i +: 4] : ~tx_o.d};
    end
  endtask : head
  task automatic tail();
    @(negedge clk_i);
    tx_o = '{1'b0, ~tx_o.d};
  endtask : tail
endmodule : pcc_mac_model

// ---- test/pcc_frame_config_monitor.sv ----
// Purpose: port checker
// Assumes: reads and writes never share a cycle
// Notes:   sh mirrors the last configuration write
`timescale 1ns/1ps
module pcc_frame_config_monitor (
  input wire logic                    CORE_CLK_I,
  input wire logic                    RST_N_I,
  input wire pcc_pkg::pcc_regbus_type REG_I,
  input wire logic [15:0]             REG_RDATA_O,
  input wire logic                    FRAME_DONE_I,
  input wire logic                    FRAME_ERR_I,
  input wire logic                    FRAME_WR_EN_O,
  input wire logic                    IRQ_SLOT_SEL_O,
  input wire logic                    IRQ_EVENT_O
);
  import pcc_pkg::*;
  logic [15:0] sh;
  wire         rd_c = REG_I.rd && REG_I.addr == CFG_ADDR;
  wire         wr_c = REG_I.wr && REG_I.addr == CFG_ADDR;
  wire         fire = FRAME_DONE_I && (FRAME_ERR_I ? sh[7] : sh[6]);
  always_ff @(posedge CORE_CLK_I)
    sh <= !RST_N_I ? 16'h0000 : wr_c ? REG_I.wdata : sh;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_err; FRAME_DONE_I && FRAME_ERR_I ##2 rd_c; endsequence
  sequence s_ok; FRAME_DONE_I && !FRAME_ERR_I ##2 rd_c; endsequence
  a_err_flag: assert property (s_err |=> REG_RDATA_O[15])
    else $error("error flag low");
  a_ok_flag: assert property (s_ok |=> REG_RDATA_O[14])
    else $error("ok flag low");
  a_flag_clear: assert property (
    (rd_c && !FRAME_DONE_I) ##1 rd_c |=> REG_RDATA_O[15:14] == 2'h0) else $error("flags kept");
  a_rsvd_zero: assert property (rd_c |=> REG_RDATA_O[13:9] == 5'h00)
    else $error("reserved set");
  a_wr_enable: assert property (wr_c |=> FRAME_WR_EN_O == $past(REG_I.wdata[0]))
    else $error("write enable");
  a_slot_sel: assert property (wr_c |=> IRQ_SLOT_SEL_O == |$past(REG_I.wdata[7:6]))
    else $error("slot select");
  a_irq_fire: assert property (fire |=> IRQ_EVENT_O)
    else $error("irq missing");
  a_irq_gate: assert property (IRQ_EVENT_O |-> $past(fire))
    else $error("irq spurious");
endmodule : pcc_frame_config_monitor
bind pcc_frame_config pcc_frame_config_monitor u_mon (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .REG_I(REG_I), .REG_RDATA_O(REG_RDATA_O),
  .FRAME_DONE_I(FRAME_DONE_I), .FRAME_ERR_I(FRAME_ERR_I), .FRAME_WR_EN_O(FRAME_WR_EN_O),
  .IRQ_SLOT_SEL_O(IRQ_SLOT_SEL_O), .IRQ_EVENT_O(IRQ_EVENT_O));

// ---- test/test_pcc_frame_config.sv ----
// Purpose: register and transmit tests
// Assumes: strap high until the final reset, own address 3
// Notes:   inputs move at the falling edge
`timescale 1ns/1ps
module test_pcc_frame_config;
  import pcc_pkg::*;
  localparam int          UNIT    = 4;
  localparam logic [47:0] DA1     = 48'h0000_5A3C_C300;
  localparam logic [47:0] DAS [4] = '{DA1, 48'h1234_5600, DA1 ^ 48'h1, DA1};
  logic           clk = 1'b0, rst_n = 1'b0, pv = 1'b0, done = 1'b0, ferr = 1'b0, strap = 1'b1;
  logic           cf, acc, wen, slot, irq;
  logic [4:0]     fpa = 5'h00;
  logic [15:0]    rdata, e;
  pcc_regbus_type rb = '0;
  pcc_tx_type     txi, txo;
  int             err_total = 0, n_checks = 0, n;
  always #12.5 clk = ~clk;
  pcc_mac_model u_pcc_mac_model (.clk_i(clk), .tx_o(txi));
  pcc_frame_config #(.BUF_UNIT(UNIT), .DA_FIRST(DA1), .DA_SECOND(DAS[1])) u_pcc_frame_config (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .STRAP_EN_I(strap), .PHY_ADDR_I(5'h03),
    .REG_I(rb), .REG_RDATA_O(rdata), .TX_I(txi), .TX_O(txo),
    .FRAME_PHYAD_VALID_I(pv), .FRAME_PHYAD_I(fpa), .FRAME_DONE_I(done),
    .FRAME_ERR_I(ferr), .CTRL_FRAME_O(cf), .ADDR_ACCEPT_O(acc),
    .FRAME_WR_EN_O(wen), .IRQ_SLOT_SEL_O(slot), .IRQ_EVENT_O(irq));
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_checks++;
    if (got !== ex)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    rb = '{a, 1'b1, 1'b0, d};
    @(negedge clk);
    rb = '0;
  endtask : wr
  // read held two cycles: the second sees the flags already cleared
  task automatic rd2(input logic [15:0] ex);
    @(negedge clk);
    rb = '{CFG_ADDR, 1'b0, 1'b1, 16'h0000};
    @(negedge clk);
    chk("cfg", ex, rdata);
    @(negedge clk);
    rb = '0;
    chk("cfg", ex & 16'h3FFF, rdata);
  endtask : rd2
  task automatic finish_test();
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    // the strap lands at the first edge after release, so read from the third
    @(negedge clk);
    rd2(16'h0001);
    wr(CFG_ADDR, 16'hFFFF);
    wr(5'h10, 16'h0000);
    rd2(16'h01FF);
    chk("wen", 1'b1, wen);
    for (int k = 0; k < 8; k++)
    begin
      e = {8'h00, k[1:0], k[1], 5'h00};
      wr(CFG_ADDR, e);
      @(negedge clk);
      {done, ferr, pv} = {1'b1, k[2], 1'b1};
      fpa = k[0] ? 5'h03 : BCAST_PHYAD;
      @(negedge clk);
      {done, pv} = 2'b00;
      chk("irq", k[2] ? k[1] : k[0], irq);
      chk("slot", |k[1:0], slot);
      chk("acc", !k[1] || k[0], acc);
      rd2(e | {k[2], !k[2], 14'h0000});
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(CFG_ADDR, {7'h00, k[0], 5'h00, k[1], 2'h0});
      fork
        u_pcc_mac_model.head(DAS[k]);
        begin
          n = 0;
          @(negedge clk);
          while (txo.en !== 1'b1 && n < 99)
          begin
            @(negedge clk);
            n++;
          end
          repeat (12) @(negedge clk);
          chk("da_last", 1'b1, txo.en);
        end
      join
      chk("delay", 16'(1 + k[1] * 2 * UNIT), 16'(n));
      chk("ctrl", k != 3, cf);
      chk("txen", k[1], txo.en);
      u_pcc_mac_model.tail();
      repeat (12) @(negedge clk);
    end
    strap = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    rd2(16'h0000);
    chk("wen", 1'b0, wen);
    finish_test();
  end
endmodule : test_pcc_frame_config
